// [logic/port_status_pkg.sv]
`default_nettype none
package port_status_pkg;

   // port count and the two ports that carry far-end fault status
   localparam int NUM_PORTS = 3;
   localparam int FEF_PORTS = 2;

   // register map, byte offsets on the management register port
   localparam logic [7:0] PORT_STRIDE = 8'h10;
   localparam logic [7:0] STATUS_LO = 8'h0F;
   localparam logic [7:0] RATE_IN_LO = 8'h0A;
   localparam logic [7:0] RATE_OUT_LO = 8'h0B;
   localparam logic [7:0] RESET_OFS = 8'h43;

   // field positions
   localparam int SPEED_BIT = 2;
   localparam int DUPLEX_BIT = 1;
   localparam int FEF_BIT = 0;
   localparam int SOFT_RST_BIT = 4;
   localparam int PCS_RST_BIT = 0;
   localparam int RATE_W = 7;
   localparam int STAT_W = 3;
   localparam int KBPS_W = 17;

   // rate-limit code points
   localparam logic [RATE_W-1:0] CODE_NONE = 7'h00;
   localparam logic [RATE_W-1:0] CODE_MAX_100 = 7'h63;
   localparam logic [RATE_W-1:0] CODE_FULL_100 = 7'h64;
   localparam logic [RATE_W-1:0] CODE_MAX_10 = 7'h09;
   localparam logic [RATE_W-1:0] CODE_FULL_10 = 7'h0A;
   localparam logic [RATE_W-1:0] CODE_SUB_BASE = 7'h64;
   localparam logic [RATE_W-1:0] CODE_SUB_LAST = 7'h73;

   // target rates in kbps
   localparam logic [KBPS_W-1:0] FULL_100_KBPS = 17'h186A0;
   localparam logic [KBPS_W-1:0] FULL_10_KBPS = 17'h02710;
   localparam logic [KBPS_W-1:0] KBPS_PER_MBPS = 17'h003E8;
   localparam logic [KBPS_W-1:0] SUB_STEP_KBPS = 17'h00040;

   // link state reported by one port's PHY or MAC
   typedef struct packed {
      logic up;
      logic speed_100;
      logic full_duplex;
      logic far_fault;
   } link_s;

   // one register access request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   // whole state of the register bank
   typedef struct packed {
      logic [NUM_PORTS-1:0][STAT_W-1:0] status;
      logic [NUM_PORTS-1:0][RATE_W-1:0] rate_in;
      logic [NUM_PORTS-1:0][RATE_W-1:0] rate_out;
      logic soft_rst;
      logic pcs_rst;
      logic [7:0] rdata;
      logic rvalid;
      logic [NUM_PORTS-1:0][KBPS_W-1:0] in_kbps;
      logic [NUM_PORTS-1:0][KBPS_W-1:0] out_kbps;
      logic strap_done;
      logic [7:0] strap;
   } regs_s;

   localparam regs_s REGS_RESET = '0;

   // byte address of a per-port register
   function automatic logic [7:0] port_addr(input int p, input logic [7:0] lo);
      logic [7:0] base;
      base = 8'((p + 1) * PORT_STRIDE);
      return base + lo;
   endfunction

endpackage
`default_nettype wire

// [logic/rate_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module rate_decode
(
   // setting and link speed
   input wire logic [port_status_pkg::RATE_W-1:0] code,
   input wire logic speed_100,
   // decoded target rate
   output logic [port_status_pkg::KBPS_W-1:0] rate_kbps
);

   logic [port_status_pkg::RATE_W-1:0] max_code;
   logic [port_status_pkg::KBPS_W-1:0] full_rate;
   logic [port_status_pkg::RATE_W-1:0] sub_idx;

   // whole-megabit codes scale by 1000, sub-megabit codes step by 64 kbps;
   // anything undefined falls back to no limit so a bad code never starves a port
   always_comb
   begin
      max_code = speed_100 ? port_status_pkg::CODE_MAX_100 : port_status_pkg::CODE_MAX_10;
      full_rate = speed_100 ? port_status_pkg::FULL_100_KBPS : port_status_pkg::FULL_10_KBPS;
      sub_idx = code - port_status_pkg::CODE_SUB_BASE;
      rate_kbps = full_rate;
      if (code == port_status_pkg::CODE_NONE)
      begin
         rate_kbps = full_rate;
      end
      else if (code <= max_code)
      begin
         rate_kbps = {10'h000, code} * port_status_pkg::KBPS_PER_MBPS;
      end
      else if (code > port_status_pkg::CODE_SUB_BASE && code <= port_status_pkg::CODE_SUB_LAST)
      begin
         rate_kbps = {10'h000, sub_idx} * port_status_pkg::SUB_STEP_KBPS;
      end
   end

endmodule
`default_nettype wire

// [logic/port_status_reset_rate_limit.sv]
`timescale 1ns/100ps
`default_nettype none
module port_status_reset_rate_limit
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register access
   input wire port_status_pkg::reg_req_s reg_req,
   output var logic [7:0] reg_rdata,
   output var logic reg_rvalid,
   // per-port link state
   input wire port_status_pkg::link_s [port_status_pkg::NUM_PORTS-1:0] link,
   // strap pins, caught once after reset release
   input wire logic [7:0] strap_pins,
   output var logic [7:0] strap_cfg,
   // resets driven to the rest of the switch
   output var logic soft_reset,
   output var logic pcs_reset,
   // decoded target rates per port
   output var logic [port_status_pkg::NUM_PORTS-1:0][port_status_pkg::KBPS_W-1:0] ingress_kbps,
   output var logic [port_status_pkg::NUM_PORTS-1:0][port_status_pkg::KBPS_W-1:0] egress_kbps
);

   port_status_pkg::regs_s r;
   port_status_pkg::regs_s n;
   logic [port_status_pkg::NUM_PORTS-1:0][port_status_pkg::KBPS_W-1:0] dec_in;
   logic [port_status_pkg::NUM_PORTS-1:0][port_status_pkg::KBPS_W-1:0] dec_out;

   // one decoder per direction and port, steered by the port's reported speed
   genvar gp;
   generate
      for (gp = 0; gp < port_status_pkg::NUM_PORTS; gp++)
      begin : g_port
         rate_decode u_dec_in
         (
            .code(r.rate_in[gp]),
            .speed_100(r.status[gp][port_status_pkg::SPEED_BIT]),
            .rate_kbps(dec_in[gp])
         );
         rate_decode u_dec_out
         (
            .code(r.rate_out[gp]),
            .speed_100(r.status[gp][port_status_pkg::SPEED_BIT]),
            .rate_kbps(dec_out[gp])
         );
      end
   endgenerate

   // next state: status refresh, register writes, read mux, strap capture
   always_comb
   begin
      n = r;
      n.rvalid = 1'b0;
      for (int p = 0; p < port_status_pkg::NUM_PORTS; p++)
      begin
         n.status[p][port_status_pkg::SPEED_BIT] = link[p].up & link[p].speed_100;
         n.status[p][port_status_pkg::DUPLEX_BIT] = link[p].up & link[p].full_duplex;
         n.status[p][port_status_pkg::FEF_BIT] = (p < port_status_pkg::FEF_PORTS) ?
            link[p].far_fault : 1'b0;
         n.in_kbps[p] = dec_in[p];
         n.out_kbps[p] = dec_out[p];
      end
      if (reg_req.wr)
      begin
         if (reg_req.addr == port_status_pkg::RESET_OFS)
         begin
            n.soft_rst = reg_req.wdata[port_status_pkg::SOFT_RST_BIT];
            n.pcs_rst = reg_req.wdata[port_status_pkg::PCS_RST_BIT];
         end
         for (int p = 0; p < port_status_pkg::NUM_PORTS; p++)
         begin
            if (reg_req.addr == port_status_pkg::port_addr(p, port_status_pkg::RATE_IN_LO))
            begin
               n.rate_in[p] = reg_req.wdata[port_status_pkg::RATE_W-1:0];
            end
            if (reg_req.addr == port_status_pkg::port_addr(p, port_status_pkg::RATE_OUT_LO))
            begin
               n.rate_out[p] = reg_req.wdata[port_status_pkg::RATE_W-1:0];
            end
         end
      end
      if (reg_req.rd)
      begin
         // unmapped addresses and reserved bits read as zero
         n.rvalid = 1'b1;
         n.rdata = 8'h00;
         if (reg_req.addr == port_status_pkg::RESET_OFS)
         begin
            n.rdata[port_status_pkg::SOFT_RST_BIT] = r.soft_rst;
            n.rdata[port_status_pkg::PCS_RST_BIT] = r.pcs_rst;
         end
         for (int p = 0; p < port_status_pkg::NUM_PORTS; p++)
         begin
            if (reg_req.addr == port_status_pkg::port_addr(p, port_status_pkg::STATUS_LO))
            begin
               n.rdata[port_status_pkg::STAT_W-1:0] = r.status[p];
            end
            if (reg_req.addr == port_status_pkg::port_addr(p, port_status_pkg::RATE_IN_LO))
            begin
               n.rdata[port_status_pkg::RATE_W-1:0] = r.rate_in[p];
            end
            if (reg_req.addr == port_status_pkg::port_addr(p, port_status_pkg::RATE_OUT_LO))
            begin
               n.rdata[port_status_pkg::RATE_W-1:0] = r.rate_out[p];
            end
         end
      end
      // strap level caught on the first clock after release, never by the reset itself
      if (!r.strap_done)
      begin
         n.strap_done = 1'b1;
         n.strap = strap_pins;
      end
      // soft reset wipes all but straps
      if (r.soft_rst)
      begin
         n = port_status_pkg::REGS_RESET;
         n.strap_done = r.strap_done;
         n.strap = r.strap;
      end
   end

   // single state register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r <= port_status_pkg::REGS_RESET;
      end
      else
      begin
         r <= n;
      end
   end

   // outputs straight from state
   assign reg_rdata = r.rdata;
   assign reg_rvalid = r.rvalid;
   assign strap_cfg = r.strap;
   assign soft_reset = r.soft_rst;
   assign pcs_reset = r.pcs_rst;
   assign ingress_kbps = r.in_kbps;
   assign egress_kbps = r.out_kbps;

   // checks on the bank's own behaviour
   AST_SPEED_100: assert property (
      @(posedge clk) disable iff (!reset_n)
      (link[0].up && link[0].speed_100 && !r.soft_rst) |=> r.status[0][port_status_pkg::SPEED_BIT])
      else $error("speed bit not set at 100 Mbps");

   AST_DUPLEX: assert property (
      @(posedge clk) disable iff (!reset_n)
      !r.soft_rst |=> r.status[1][port_status_pkg::DUPLEX_BIT] ==
         ($past(link[1].up) && $past(link[1].full_duplex)))
      else $error("duplex bit does not follow link");

   AST_FEF_PORT3: assert property (
      @(posedge clk) disable iff (!reset_n)
      r.status[2][port_status_pkg::FEF_BIT] == 1'b0)
      else $error("far-end fault shown on mii port");

   AST_FEF_PHY: assert property (
      @(posedge clk) disable iff (!reset_n)
      (link[0].far_fault && !r.soft_rst) |=> r.status[0][port_status_pkg::FEF_BIT])
      else $error("far-end fault missed on phy port");

   AST_SOFT_RESET: assert property (
      @(posedge clk) disable iff (!reset_n)
      r.soft_rst |=> (r.rate_in == '0 && r.rate_out == '0 && !r.soft_rst && !r.pcs_rst
         && r.strap == $past(r.strap)))
      else $error("soft reset did not restore defaults");

   AST_PCS_RESET: assert property (
      @(posedge clk) disable iff (!reset_n)
      (reg_req.wr && reg_req.addr == port_status_pkg::RESET_OFS && !r.soft_rst)
         |=> pcs_reset == $past(reg_req.wdata[port_status_pkg::PCS_RST_BIT]))
      else $error("pcs reset does not follow write");

   AST_RATE_FIELD: assert property (
      @(posedge clk) disable iff (!reset_n)
      (reg_req.wr && !r.soft_rst
         && reg_req.addr == port_status_pkg::port_addr(1, port_status_pkg::RATE_IN_LO))
         |=> r.rate_in[1] == $past(reg_req.wdata[port_status_pkg::RATE_W-1:0]))
      else $error("ingress rate field not stored");

   AST_RATE_100: assert property (
      @(posedge clk) disable iff (!reset_n)
      (r.status[0][port_status_pkg::SPEED_BIT] && !r.soft_rst
         && (r.rate_in[0] == port_status_pkg::CODE_FULL_100
         || r.rate_in[0] == port_status_pkg::CODE_NONE))
         |=> ingress_kbps[0] == port_status_pkg::FULL_100_KBPS)
      else $error("100 Mbit full-rate code wrong");

   AST_RATE_10: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!r.status[0][port_status_pkg::SPEED_BIT] && !r.soft_rst && r.rate_in[0] == 7'h05)
         |=> ingress_kbps[0] == 17'h01388)
      else $error("10 Mbit 5 Mbps code wrong");

   AST_RATE_SUB: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!r.soft_rst && r.rate_in[2] == 7'h6D) |=> ingress_kbps[2] == 17'h00240)
      else $error("576 kbps code wrong");

   AST_EGRESS: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!r.soft_rst && r.rate_out[1] == 7'h73) |=> egress_kbps[1] == 17'h003C0)
      else $error("egress 960 kbps code wrong");

   AST_LINK_DOWN: assert property (
      @(posedge clk) disable iff (!reset_n)
      !link[2].up |=> (r.status[2][port_status_pkg::SPEED_BIT] == 1'b0
         && r.status[2][port_status_pkg::DUPLEX_BIT] == 1'b0))
      else $error("status not cleared on link down");

   // main scenarios
   COV_SOFT_RESET: cover property (@(posedge clk) disable iff (!reset_n) soft_reset && pcs_reset);
   COV_LINK_UP_100: cover property (@(posedge clk) disable iff (!reset_n)
      r.status[0][port_status_pkg::SPEED_BIT] && r.status[0][port_status_pkg::DUPLEX_BIT]);
   // lowest sub-megabit step, reached on port 2 ingress
   COV_SUB_RATE: cover property (@(posedge clk) disable iff (!reset_n)
      ingress_kbps[1] == port_status_pkg::SUB_STEP_KBPS);
   COV_READ: cover property (@(posedge clk) disable iff (!reset_n) reg_rvalid && reg_rdata != 8'h00);

endmodule
`default_nettype wire

// [testbench/port_status_reset_rate_limit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module port_status_reset_rate_limit_tb;
   logic clk;
   logic reset_n;
   port_status_pkg::reg_req_s reg_req;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   port_status_pkg::link_s [2:0] link;
   logic [7:0] strap_pins;
   logic [7:0] strap_cfg;
   logic soft_reset;
   logic pcs_reset;
   logic [2:0][16:0] ingress_kbps;
   logic [2:0][16:0] egress_kbps;
   int miscompares = 0;
   int cmp_count = 0;

   port_status_reset_rate_limit i_port_status_reset_rate_limit
   (
      .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .link(link), .strap_pins(strap_pins), .strap_cfg(strap_cfg),
      .soft_reset(soft_reset), .pcs_reset(pcs_reset), .ingress_kbps(ingress_kbps),
      .egress_kbps(egress_kbps)
   );

   // free-running 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("miscompares %0d, comparisons %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one-cycle write strobe, returns just after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      reg_req.addr = a;
      reg_req.wdata = d;
      reg_req.wr = 1'b1;
      @(posedge clk) #1;
      reg_req.wr = 1'b0;
   endtask

   // one-cycle read strobe; the answer stands in the cycle after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) #1;
      reg_req.addr = a;
      reg_req.rd = 1'b1;
      @(posedge clk) #1;
      reg_req.rd = 1'b0;
      check({16'h0000, reg_rvalid}, 17'h00001);
      check({9'h000, reg_rdata}, {9'h000, exp});
   endtask

   // expected rate from the decode tables, kept independent of the design
   function automatic logic [16:0] exp_kbps(input logic [6:0] c, input logic s100);
      if (c >= 7'h65 && c <= 7'h73)
         return 17'((c - 7'h64) * 17'h00040);
      if (c != 7'h00 && c <= (s100 ? 7'h63 : 7'h09))
         return 17'(c * 17'h003E8);
      return s100 ? 17'h186A0 : 17'h02710;
   endfunction

   task automatic t_reset_defaults();
      int p;
      check({9'h000, strap_cfg}, 17'h000A5);
      for (p = 0; p < 3; p++)
      begin
         rd(8'h1F + 8'(p * 16), 8'h00);
         rd(8'h1A + 8'(p * 16), 8'h00);
         check(ingress_kbps[p], 17'h02710);
      end
      rd(8'h43, 8'h00);
      rd(8'h05, 8'h00);
   endtask

   // speed, duplex and far-end fault follow the link inputs, the fault on ports 1 and 2 only
   task automatic t_status();
      link[0] = '{1'b1, 1'b1, 1'b1, 1'b1};
      link[1] = '{1'b1, 1'b0, 1'b1, 1'b0};
      link[2] = '{1'b1, 1'b1, 1'b0, 1'b1};
      rd(8'h1F, 8'h07);
      rd(8'h2F, 8'h02);
      rd(8'h3F, 8'h04);
      wr(8'h2F, 8'hFF);
      rd(8'h2F, 8'h02);
      link[0] = '{1'b0, 1'b1, 1'b1, 1'b1};
      rd(8'h1F, 8'h01);
   endtask

   // codes across both speeds, alternating ingress and egress on all ports
   task automatic t_rate_table();
      logic [6:0] codes [12] = '{7'h00, 7'h01, 7'h63, 7'h64, 7'h65, 7'h6D, 7'h73, 7'h00,
                                 7'h09, 7'h0A, 7'h30, 7'h7F};
      logic spd [12] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                         1'b1};
      int i;
      int p;
      for (i = 0; i < 12; i++)
      begin
         p = i % 3;
         link[p] = '{1'b1, spd[i], 1'b0, 1'b0};
         wr(8'h1A + 8'(p * 16) + 8'(i % 2), {1'b0, codes[i]});
         repeat (3) @(posedge clk);
         #1;
         if (i % 2 == 0)
            check(ingress_kbps[p], exp_kbps(codes[i], spd[i]));
         else
            check(egress_kbps[p], exp_kbps(codes[i], spd[i]));
      end
      wr(8'h2A, 8'hFF);
      rd(8'h2A, 8'h7F);
      link[0] = '{1'b1, 1'b1, 1'b0, 1'b0};
      wr(8'h1A, 8'h6D);
      wr(8'h1B, 8'h05);
      repeat (2) @(posedge clk);
      #1;
      check(ingress_kbps[0], 17'h00240);
      check(egress_kbps[0], 17'h01388);
      // port 1 at 10 Mbit, sub-rate on port 3 ingress, top sub-rate on port 2 egress
      link[0] = '{1'b1, 1'b0, 1'b0, 1'b0};
      wr(8'h1A, 8'h05);
      wr(8'h3A, 8'h6D);
      wr(8'h2B, 8'h73);
      repeat (2) @(posedge clk);
      #1;
      check(ingress_kbps[0], 17'h01388);
      check(ingress_kbps[2], 17'h00240);
      check(egress_kbps[1], 17'h003C0);
   endtask

   // soft reset with the sublayer bit set alongside, strap value must survive
   task automatic t_soft_reset();
      link = '0;
      strap_pins = 8'h5A;
      wr(8'h2B, 8'h0C);
      wr(8'h43, 8'h11);
      check({16'h0000, soft_reset}, 17'h00001);
      check({16'h0000, pcs_reset}, 17'h00001);
      @(posedge clk) #1;
      check({15'h0000, soft_reset, pcs_reset}, 17'h00000);
      rd(8'h2B, 8'h00);
      rd(8'h43, 8'h00);
      check(egress_kbps[1], 17'h02710);
      check({9'h000, strap_cfg}, 17'h000A5);
   endtask

   // sublayer reset as a held level, other bits of the reset register read zero
   task automatic t_pcs_reset();
      wr(8'h43, 8'h2F);
      @(posedge clk) #1;
      check({15'h0000, soft_reset, pcs_reset}, 17'h00001);
      rd(8'h43, 8'h01);
      wr(8'h43, 8'h00);
      @(posedge clk) #1;
      check({16'h0000, pcs_reset}, 17'h00000);
   endtask

   // drive everything at time zero, reset for 16 cycles, then run scenarios
   initial
   begin
      reset_n = 1'b0;
      reg_req = '0;
      link = '0;
      strap_pins = 8'hA5;
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_reset_defaults();
      t_status();
      t_rate_table();
      t_soft_reset();
      t_pcs_reset();
      summarize();
   end

   // watchdog, far beyond the roughly 150 cycles the scenarios need
   initial
   begin
      #(20000 * 100);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
